// ### fcs_cmd.sv
// command interpreter: parameter collection, execution and result bytes
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// R1 - format: density bit 6, five params, four id bytes per sector, seven results
// R2 - recalibrate steps selected drive to cylinder 0, then interrupts, no result
// R3 - sense interrupt returns status zero then present cylinder after seeks
// R4 - seek takes drive byte and target cylinder, moves head, no result
// R5 - relative seek: bit 7 set, bit 6 direction, third byte is step count
// R6 - configure stores implied seek, fifo, polling, threshold and precomp track
// R7 - dump registers returns ten bytes in fixed order
// R8 - perpendicular byte: overwrite bit 7, drive enables 5..2, gap and gate stored
// R9 - lock value from command bit 7 returned alone in result bit 4
// R10 - sense drive status takes drive byte, returns status byte three
// R11 - undefined codes do nothing and return status zero of 80 hex
// R12 - specify stores step/unload byte and load/non-dma byte, no result
module fcs_cmd (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_byte,
  input  wire logic       res_take,
  input  wire logic       track0,
  input  wire logic       write_protect,
  input  wire logic       two_sided,
  output logic            res_valid,
  output logic      [7:0] res_byte,
  output logic            cmd_busy,
  output logic            fdc_int,
  output logic            drive_pick_low,
  output logic            drive_pick_high,
  output logic            head_side_select,
  output logic            step_pulse,
  output logic            step_dir_in,
  output logic            density_mfm,
  output logic            implied_seek_enable,
  output logic            fifo_disable_flag,
  output logic            poll_disable,
  output logic      [3:0] fifo_threshold,
  output logic      [7:0] precomp_start_track,
  output logic      [7:0] perp_mode,
  output logic      [7:0] sectors_per_track,
  output logic      [7:0] gap_length
);
  import fcs_pkg::*;
  typedef enum logic [2:0] {FCS_IDLE, FCS_PARAM, FCS_EXEC,
                            FCS_RESULT} fcs_st_e;
  fcs_head_if hif();
  fcs_head_mover u_mover (
    .core_clk (core_clk),
    .rst      (rst),
    .track0   (track0),
    .hif      (hif)
  );

  fcs_st_e    st_q, st_d;
  logic [7:0] op_q, op_d, cnt_q, cnt_d, need_q, need_d;
  logic [7:0] drv_q, drv_d;
  logic [7:0] spec1_q, spec1_d, spec2_q, spec2_d, cfg_q, cfg_d;
  logic [7:0] pre_q, pre_d, perp_q, perp_d, sc_q, sc_d, gpl_q, gpl_d;
  logic       lock_q, lock_d, dens_q, dens_d, int_q, int_d;
  logic       seekend_q, seekend_d, rv_q, rv_d, busy_q, busy_d;
  logic [7:0] rb_q, rb_d, st0_q, st0_d;
  logic [1:0] pend_q, pend_d;
  logic       go_d, go_q, zero_q, zero_d;
  logic [7:0] tgt_q, tgt_d;

  // count of bytes after the code byte that each command carries
  function automatic logic [7:0] param_count(input logic [7:0] c);
    if (c[FCS_RELSEEK_BIT] && (c & FCS_OP_MASK) == FCS_OP_SEEK)
      return 8'd2; // R5
    unique case (c & FCS_OP_MASK)
      FCS_OP_FORMAT:      return 8'(FCS_FORMAT_PARAMS); // R1
      FCS_OP_RECAL:       return 8'd1;
      FCS_OP_SPECIFY:     return 8'd2; // R12
      FCS_OP_SEEK:        return 8'd2; // R4
      FCS_OP_CONFIGURE:   return 8'd3; // R6
      FCS_OP_PERP:        return 8'd1;
      FCS_OP_SENSE_DRIVE: return 8'd1; // R10
      default:            return 8'd0;
    endcase
  endfunction : param_count

  function automatic logic valid_op(input logic [7:0] c);
    logic [7:0] k;
    k = c & FCS_OP_MASK;
    if (c == FCS_OP_SENSE_INT || c == FCS_OP_DUMPREG || c == FCS_OP_RECAL
        || c == FCS_OP_SPECIFY || c == FCS_OP_CONFIGURE || c == FCS_OP_PERP
        || c == FCS_OP_SENSE_DRIVE || c == FCS_OP_SEEK) return 1'b1;
    if (k == FCS_OP_FORMAT && (c & 8'hb0) == 8'h00) return 1'b1;
    if (k == FCS_OP_SEEK && c[FCS_RELSEEK_BIT] && !c[5] && !c[4]) return 1'b1;
    if (k == FCS_OP_LOCK && (c & 8'h7f) == FCS_OP_LOCK) return 1'b1;
    return 1'b0;
  endfunction : valid_op

  always_comb begin
    st_d = st_q; op_d = op_q; cnt_d = cnt_q; need_d = need_q;
    drv_d = drv_q; spec1_d = spec1_q; spec2_d = spec2_q;
    cfg_d = cfg_q; pre_d = pre_q; perp_d = perp_q; sc_d = sc_q;
    gpl_d = gpl_q; lock_d = lock_q; dens_d = dens_q; int_d = int_q;
    seekend_d = seekend_q; rv_d = rv_q; rb_d = rb_q; st0_d = st0_q;
    pend_d = pend_q; go_d = 1'b0; zero_d = zero_q; tgt_d = tgt_q;
    busy_d = (st_q != FCS_IDLE);
    unique case (st_q)
      FCS_IDLE: if (cmd_valid && !hif.busy) begin
        op_d = cmd_byte; cnt_d = 8'h00;
        if (!valid_op(cmd_byte)) begin
          st_d = FCS_RESULT; need_d = 8'd1; // R11
        end else if (param_count(cmd_byte) != 8'h00) begin
          st_d = FCS_PARAM; need_d = param_count(cmd_byte);
          if ((cmd_byte & FCS_OP_MASK) == FCS_OP_FORMAT)
            dens_d = cmd_byte[FCS_DENSITY_BIT]; // R1
        end else if (cmd_byte == FCS_OP_SENSE_INT) begin
          st_d = FCS_RESULT; need_d = seekend_q ? 8'd2 : 8'd1; // R3
          if (!seekend_q) op_d = 8'h00;
        end else if (cmd_byte == FCS_OP_DUMPREG) begin
          st_d = FCS_RESULT; need_d = 8'(FCS_DUMP_RESULTS); // R7
        end else begin
          lock_d = cmd_byte[FCS_LOCK_BIT]; // R9
          st_d = FCS_RESULT; need_d = 8'd1;
        end
      end
      FCS_PARAM: if (cmd_valid) begin
        cnt_d = cnt_q + 8'h01;
        // only drive-bearing commands move the select pins
        unique case (op_q & FCS_OP_MASK)
          FCS_OP_SPECIFY: if (cnt_q == 8'h00) spec1_d = cmd_byte; // R12
                          else spec2_d = cmd_byte;
          FCS_OP_CONFIGURE: if (cnt_q == 8'h01) cfg_d = cmd_byte & 8'h7f; // R6
                            else if (cnt_q == 8'h02) pre_d = cmd_byte;
          FCS_OP_PERP: perp_d = {cmd_byte[7], 1'b0, cmd_byte[5:0]}; // R8
          FCS_OP_FORMAT: begin
            if (cnt_q == 8'h00) drv_d = cmd_byte;
            if (cnt_q == 8'h02) sc_d = cmd_byte;
            if (cnt_q == 8'h03) gpl_d = cmd_byte;
          end
          default: if (cnt_q == 8'h00) drv_d = cmd_byte;
        endcase
        if (cnt_d == need_q) begin
          cnt_d = 8'h00;
          unique case (op_q & FCS_OP_MASK)
            FCS_OP_RECAL, FCS_OP_SEEK: begin
              st_d = FCS_EXEC; go_d = 1'b1; seekend_d = 1'b0;
              zero_d = (op_q == FCS_OP_RECAL); // R2
              tgt_d = cmd_byte; // R4
              if (op_q[FCS_RELSEEK_BIT]) // R5
                tgt_d = op_q[FCS_DIR_BIT] ?
                  hif.cyl[drv_q[1:0]] + cmd_byte :
                  hif.cyl[drv_q[1:0]] - cmd_byte;
            end
            FCS_OP_FORMAT: begin
              st_d = FCS_EXEC; need_d = 8'(FCS_FORMAT_ID_BYTES) * sc_q;
            end
            FCS_OP_SENSE_DRIVE: begin
              st_d = FCS_RESULT; need_d = 8'd1; // R10
            end
            default: st_d = FCS_IDLE;
          endcase
        end
      end
      FCS_EXEC: begin
        if ((op_q & FCS_OP_MASK) == FCS_OP_FORMAT) begin
          // id bytes are taken but no media is written here
          if (need_q == 8'h00) begin
            st_d = FCS_RESULT; need_d = 8'(FCS_FORMAT_RESULTS);
            cnt_d = 8'h00; int_d = 1'b1;
          end else if (cmd_valid) need_d = need_q - 8'h01; // R1
        end else if (!go_q && !hif.busy) st_d = FCS_IDLE; // R4
      end
      FCS_RESULT: begin
        if (!rv_q) begin
          rv_d = 1'b1;
          rb_d = 8'h00;
          if (!valid_op(op_q)) rb_d = FCS_INVALID_ST0; // R11
          else unique case (op_q & FCS_OP_MASK)
            FCS_OP_SENSE_INT: begin
              rb_d = (cnt_q == 8'h00) ? st0_q : hif.cyl[pend_q]; // R3
              if (need_q == 8'd1) rb_d = FCS_INVALID_ST0;
            end
            FCS_OP_DUMPREG: unique case (cnt_q) // R7
              8'd0, 8'd1, 8'd2, 8'd3: rb_d = hif.cyl[cnt_q[1:0]];
              8'd4: rb_d = spec1_q;
              8'd5: rb_d = spec2_q;
              8'd6: rb_d = sc_q;
              8'd7: rb_d = {lock_q, perp_q[6:0]};
              8'd8: rb_d = cfg_q;
              default: rb_d = pre_q;
            endcase
            FCS_OP_LOCK: rb_d[FCS_LOCK_RES_BIT] = lock_q; // R9
            FCS_OP_SENSE_DRIVE: rb_d = {1'b0, write_protect, 1'b1, track0,
                                  two_sided, drv_q[2:0]}; // R10
            FCS_OP_FORMAT: if (cnt_q == 8'h00)
                             rb_d = {5'h00, drv_q[2:0]}; // R1
            default: rb_d = 8'h00;
          endcase
        end else if (res_take) begin
          rv_d = 1'b0; cnt_d = cnt_q + 8'h01;
          if (op_q == FCS_OP_SENSE_INT) begin
            int_d = 1'b0; seekend_d = 1'b0;
          end
          if (cnt_d == need_q) st_d = FCS_IDLE;
        end
      end
      default: st_d = FCS_IDLE;
    endcase
    // seek completion is applied last so it wins over a same-cycle clear
    if (hif.done) begin
      int_d = 1'b1; // R2
      seekend_d = 1'b1;
      st0_d = FCS_SEEK_END_ST0 | {6'h00, hif.drive};
      pend_d = hif.drive;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= FCS_IDLE; op_q <= 8'h00; cnt_q <= 8'h00; need_q <= 8'h00;
      drv_q <= 8'h00; spec1_q <= FCS_SPECIFY_RST;
      spec2_q <= FCS_SPECIFY_RST; cfg_q <= FCS_CONFIG_RST;
      pre_q <= FCS_PRECOMP_START_TRACK_RST; perp_q <= FCS_PERP_RST; sc_q <= 8'h00;
      gpl_q <= 8'h00; lock_q <= 1'b0; dens_q <= 1'b0; int_q <= 1'b0;
      seekend_q <= 1'b0; rv_q <= 1'b0; rb_q <= 8'h00; st0_q <= 8'h00;
      pend_q <= 2'h0; go_q <= 1'b0; zero_q <= 1'b0; tgt_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d; op_q <= op_d; cnt_q <= cnt_d; need_q <= need_d;
      drv_q <= drv_d; spec1_q <= spec1_d;
      spec2_q <= spec2_d; cfg_q <= cfg_d; pre_q <= pre_d;
      perp_q <= perp_d; sc_q <= sc_d; gpl_q <= gpl_d; lock_q <= lock_d;
      dens_q <= dens_d; int_q <= int_d; seekend_q <= seekend_d;
      rv_q <= rv_d; rb_q <= rb_d; st0_q <= st0_d; pend_q <= pend_d;
      go_q <= go_d; zero_q <= zero_d; tgt_q <= tgt_d; busy_q <= busy_d;
    end
  end

  assign hif.go      = go_q;
  assign hif.drive   = drv_q[1:0];
  assign hif.target  = tgt_q;
  assign hif.to_zero = zero_q;
  assign hif.rate    = spec1_q[7:4];

  assign res_valid           = rv_q;
  assign res_byte            = rb_q;
  assign cmd_busy            = busy_q;
  assign fdc_int             = int_q;
  assign drive_pick_low      = drv_q[0];
  assign drive_pick_high     = drv_q[1];
  assign head_side_select    = drv_q[FCS_HEAD_BIT];
  assign step_pulse          = hif.step;
  assign step_dir_in         = hif.dir_in;
  assign density_mfm         = dens_q;
  assign implied_seek_enable = cfg_q[6];
  assign fifo_disable_flag   = cfg_q[5];
  assign poll_disable        = cfg_q[4];
  assign fifo_threshold      = cfg_q[3:0];
  assign precomp_start_track = pre_q;
  assign perp_mode           = perp_q;
  assign sectors_per_track   = sc_q;
  assign gap_length          = gpl_q;
endmodule : fcs_cmd
`default_nettype wire

// ### fcs_cmd_sva.sv
// checker: timing relations at the command interpreter's ports
`timescale 1ns/1ns
`default_nettype none
module fcs_cmd_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       res_take,
  input wire logic       res_valid,
  input wire logic [7:0] res_byte,
  input wire logic       cmd_busy,
  input wire logic       fdc_int,
  input wire logic       drive_pick_low,
  input wire logic       head_side_select,
  input wire logic       step_pulse,
  input wire logic       fifo_disable_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // code byte offered while nothing is in flight
  sequence idle_byte(logic [7:0] op);
    !cmd_busy && !res_valid && !$past(cmd_valid) && cmd_valid &&
      cmd_byte == op;
  endsequence
  sequence sense_drive;
    idle_byte(8'h04) ##1 !cmd_valid ##1 cmd_valid;
  endsequence
  a_invalid_result: assert property (idle_byte(8'h00) |->
    ##[1:3] (res_valid && res_byte == 8'h80))
    else $error("invalid code result wrong");
  a_lock_set: assert property (idle_byte(8'h94) |->
    ##[1:3] (res_valid && res_byte == 8'h10))
    else $error("lock set result wrong");
  a_lock_clear: assert property (idle_byte(8'h14) |->
    ##[1:3] (res_valid && res_byte == 8'h00))
    else $error("lock clear result wrong");
  a_result_stands: assert property (res_valid && !res_take |=>
    res_valid && $stable(res_byte))
    else $error("result byte not held");
  a_result_pop: assert property (res_valid && res_take |=>
    !res_valid)
    else $error("result not removed on take");
  a_int_holds: assert property (fdc_int && !res_take |=> fdc_int)
    else $error("interrupt dropped without read");
  a_step_spacing: assert property (step_pulse |=>
    !step_pulse [*8])
    else $error("step pulses too close");
  a_drive_byte: assert property (sense_drive |=>
    drive_pick_low == $past(cmd_byte[0]) &&
    head_side_select == $past(cmd_byte[2]))
    else $error("drive select pins wrong");
  a_reset_values: assert property (disable iff (1'b0)
    rst && $past(rst) |-> !fdc_int && !res_valid &&
    fifo_disable_flag && !step_pulse)
    else $error("reset values wrong");
endmodule : fcs_cmd_sva
bind fcs_cmd fcs_cmd_sva u_sva (.*);
`default_nettype wire

// ### fcs_drive_model.sv
// drive model: head position per drive and track zero sense
`timescale 1ns/1ns
`default_nettype none
module fcs_drive_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic step_pulse,
  input  wire logic step_dir_in,
  input  wire logic drive_pick_low,
  input  wire logic drive_pick_high,
  output logic      track0
);
  logic [7:0] pos [4];
  logic [1:0] sel;
  assign sel = {drive_pick_high, drive_pick_low};
  // drive 0 starts off track zero so recalibrate has to step
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pos <= '{8'h02, 8'h00, 8'h00, 8'h00};
    end else if (step_pulse) begin
      pos[sel] <= step_dir_in ? pos[sel] + 8'h01 : pos[sel] - 8'h01;
    end
  end
  assign track0 = (pos[sel] == 8'h00);
endmodule : fcs_drive_model
`default_nettype wire

// ### fcs_head_if.sv
// interface: head positioning request and completion between modules
`timescale 1ns/1ns
`default_nettype none
interface fcs_head_if;
  logic       go;
  logic [1:0] drive;
  logic [7:0] target;
  logic       to_zero;
  logic [3:0] rate;
  logic       busy;
  logic       done;
  logic [7:0] cyl [4];
  logic       step;
  logic       dir_in;
  modport ctl (output go, drive, target, to_zero, rate,
               input busy, done, cyl, step, dir_in);
  modport mover (input go, drive, target, to_zero, rate,
                 output busy, done, cyl, step, dir_in);
endinterface : fcs_head_if
`default_nettype wire

// ### fcs_head_mover.sv
// head mover: steps a drive's head to a target cylinder
`timescale 1ns/1ns
`default_nettype none
module fcs_head_mover (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic track0,
  fcs_head_if.mover hif
);
  import fcs_pkg::*;
  typedef enum logic [1:0] {FCS_H_IDLE, FCS_H_WAIT, FCS_H_PULSE} fcs_h_e;
  fcs_h_e     st_q, st_d;
  logic [1:0] drv_q, drv_d;
  logic [7:0] tgt_q, tgt_d;
  logic       zero_q, zero_d;
  logic [11:0] cnt_q, cnt_d;
  logic [7:0] cyl_q [4];
  logic [7:0] cyl_d [4];
  logic       done_q, done_d, step_q, step_d, dir_q, dir_d;
  logic       arrived;

  always_comb begin
    arrived = zero_q ? track0 : (cyl_q[drv_q] == tgt_q);
    st_d = st_q; drv_d = drv_q; tgt_d = tgt_q; zero_d = zero_q;
    cnt_d = cnt_q; cyl_d = cyl_q; done_d = 1'b0; step_d = 1'b0;
    dir_d = dir_q;
    unique case (st_q)
      FCS_H_IDLE: if (hif.go) begin
        st_d = FCS_H_WAIT; drv_d = hif.drive; tgt_d = hif.target;
        zero_d = hif.to_zero; cnt_d = 12'h000;
      end
      FCS_H_WAIT: begin
        if (arrived) begin
          st_d = FCS_H_IDLE;
          done_d = 1'b1;
          if (zero_q) cyl_d[drv_q] = 8'h00;
        end else if (cnt_q >= 12'(FCS_STEP_UNIT_CYC * (16 - hif.rate))) begin
          st_d = FCS_H_PULSE;
          dir_d = !zero_q && (tgt_q > cyl_q[drv_q]);
        end else cnt_d = cnt_q + 12'h001;
      end
      FCS_H_PULSE: begin
        step_d = 1'b1; cnt_d = 12'h000; st_d = FCS_H_WAIT;
        if (dir_q) cyl_d[drv_q] = cyl_q[drv_q] + 8'h01;
        else if (cyl_q[drv_q] != 8'h00) cyl_d[drv_q] = cyl_q[drv_q] - 8'h01;
      end
      default: st_d = FCS_H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= FCS_H_IDLE; drv_q <= 2'h0; tgt_q <= 8'h00; zero_q <= 1'b0;
      cnt_q <= 12'h000; done_q <= 1'b0; step_q <= 1'b0; dir_q <= 1'b0;
      for (int i = 0; i < 4; i++) cyl_q[i] <= 8'h00;
    end else begin
      st_q <= st_d; drv_q <= drv_d; tgt_q <= tgt_d; zero_q <= zero_d;
      cnt_q <= cnt_d; done_q <= done_d; step_q <= step_d; dir_q <= dir_d;
      cyl_q <= cyl_d;
    end
  end

  assign hif.busy   = (st_q != FCS_H_IDLE);
  assign hif.done   = done_q;
  assign hif.step   = step_q;
  assign hif.dir_in = dir_q;
  assign hif.cyl    = cyl_q;
endmodule : fcs_head_mover
`default_nettype wire

// ### fcs_pkg.sv
// package: command codes, field positions, reset values and timing counts
package fcs_pkg;
  localparam logic [7:0] FCS_OP_MASK        = 8'h1f;
  localparam logic [7:0] FCS_OP_FORMAT      = 8'h0d;
  localparam logic [7:0] FCS_OP_RECAL       = 8'h07;
  localparam logic [7:0] FCS_OP_SENSE_INT   = 8'h08;
  localparam logic [7:0] FCS_OP_SPECIFY     = 8'h03;
  localparam logic [7:0] FCS_OP_SEEK        = 8'h0f;
  localparam logic [7:0] FCS_OP_CONFIGURE   = 8'h13;
  localparam logic [7:0] FCS_OP_DUMPREG     = 8'h0e;
  localparam logic [7:0] FCS_OP_PERP        = 8'h12;
  localparam logic [7:0] FCS_OP_LOCK        = 8'h14;
  localparam logic [7:0] FCS_OP_SENSE_DRIVE = 8'h04;
  localparam logic [7:0] FCS_INVALID_ST0    = 8'h80;
  localparam logic [7:0] FCS_SEEK_END_ST0   = 8'h20;
  localparam int FCS_DENSITY_BIT  = 6;
  localparam int FCS_RELSEEK_BIT  = 7;
  localparam int FCS_DIR_BIT      = 6;
  localparam int FCS_LOCK_BIT     = 7;
  localparam int FCS_LOCK_RES_BIT = 4;
  localparam int FCS_HEAD_BIT     = 2;
  localparam int FCS_FORMAT_PARAMS = 5;
  localparam int FCS_FORMAT_ID_BYTES = 4;
  localparam int FCS_FORMAT_RESULTS = 7;
  localparam int FCS_DUMP_RESULTS = 10;
  localparam logic [7:0] FCS_SPECIFY_RST  = 8'h00;
  localparam logic [7:0] FCS_CONFIG_RST   = 8'h20;
  localparam logic [7:0] FCS_PRECOMP_START_TRACK_RST   = 8'h00;
  localparam logic [7:0] FCS_PERP_RST     = 8'h00;
  // step pulse spacing per unit of the step rate field
  localparam int FCS_CLK_MHZ       = 50;
  localparam int FCS_STEP_UNIT_US  = 1;
  localparam int FCS_STEP_UNIT_CYC = FCS_STEP_UNIT_US * FCS_CLK_MHZ;
endpackage : fcs_pkg

// ### floppy_command_set_part_bench.sv
// bench: command interpreter against a drive model
`timescale 1ns/1ns
`default_nettype none
module floppy_command_set_part_bench;
  import fcs_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cmd_valid = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic       res_take = 1'b0;
  logic       write_protect = 1'b0;
  logic       two_sided = 1'b1;
  logic       track0, res_valid, cmd_busy, fdc_int, step_pulse, step_dir_in;
  logic       drive_pick_low, drive_pick_high, head_side_select;
  logic       density_mfm, implied_seek_enable, fifo_disable_flag;
  logic       poll_disable;
  logic [3:0] fifo_threshold;
  logic [7:0] res_byte, precomp_start_track, perp_mode;
  logic [7:0] sectors_per_track, gap_length;
  int         error_cnt = 0;
  int         check_count = 0;
  int         cycles = 0;
  // code byte beside its single result byte
  logic [15:0] rows [4] = '{16'h0080, 16'h9410, 16'h1400, 16'h0880};
  logic [7:0]  dexp [10] = '{8'h00, 8'h05, 8'h00, 8'h00, 8'hf1,
                             8'h05, 8'h00, 8'h07, 8'h47, 8'h09};
  fcs_cmd u_dut (.*);
  fcs_drive_model u_drv (
    .core_clk        (core_clk),
    .rst             (rst),
    .step_pulse      (step_pulse),
    .step_dir_in     (step_dir_in),
    .drive_pick_low  (drive_pick_low),
    .drive_pick_high (drive_pick_high),
    .track0          (track0)
  );
  always #10 core_clk = ~core_clk;
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // gap first so the previous command has fully settled
  task automatic issue(input logic [7:0] q [$]);
    repeat (3) @(posedge core_clk);
    foreach (q[i]) begin
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_byte  <= q[i];
      @(posedge core_clk);
      cmd_valid <= 1'b0;
    end
  endtask : issue
  task automatic pop(input string name, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge core_clk);
    while (res_valid !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    check("res_valid", {7'h0, res_valid}, 8'h01);
    check(name, res_byte, exp);
    res_take <= 1'b1;
    @(posedge core_clk);
    res_take <= 1'b0;
  endtask : pop
  task automatic wait_int();
    int n;
    n = 0;
    while (fdc_int !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    check("fdc_int", {7'h0, fdc_int}, 8'h01);
  endtask : wait_int
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check("fifo_off", {7'h0, fifo_disable_flag}, 8'h01);
    foreach (rows[i]) begin
      issue('{rows[i][15:8]});
      pop("row", rows[i][7:0]);
    end
    issue('{8'h03, 8'hf1, 8'h05});
    issue('{8'h13, 8'h00, 8'h47, 8'h09});
    issue('{8'h12, 8'h87});
    repeat (3) @(posedge core_clk);
    check("cfg", {1'b0, implied_seek_enable, fifo_disable_flag,
                  poll_disable, fifo_threshold}, 8'h47);
    check("precomp_start_track", precomp_start_track, 8'h09);
    check("perp", perp_mode, 8'h87);
    issue('{8'h0f, 8'h01, 8'h03});
    wait_int();
    issue('{8'h08});
    pop("st0", 8'h21);
    pop("pcn", 8'h03);
    check("pos1", u_drv.pos[1], 8'h03);
    issue('{8'hcf, 8'h01, 8'h02});
    wait_int();
    issue('{8'h08});
    pop("st0", 8'h21);
    pop("pcn", 8'h05);
    check("pos1", u_drv.pos[1], 8'h05);
    issue('{8'h07, 8'h00});
    wait_int();
    issue('{8'h08});
    pop("st0", 8'h20);
    pop("pcn", 8'h00);
    check("pos0", u_drv.pos[0], 8'h00);
    issue('{8'h0e});
    foreach (dexp[i]) pop("dump", dexp[i]);
    issue('{8'h4d, 8'h00, 8'h02, 8'h01, 8'h1b, 8'he5,
            8'h00, 8'h00, 8'h01, 8'h02});
    repeat (7) pop("fmt", 8'h00);
    check("spt", sectors_per_track, 8'h01);
    check("gap", gap_length, 8'h1b);
    check("mfm", {7'h0, density_mfm}, 8'h01);
    issue('{8'h04, 8'h05});
    repeat (4) @(posedge core_clk);
    check("pick", {5'h0, head_side_select, drive_pick_high,
                   drive_pick_low}, 8'h05);
    check("st3_ready", {7'h0, res_valid}, 8'h01);
    check("st3", res_byte, 8'h2d);
    check("busy", {7'h0, cmd_busy}, 8'h01);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("rst_int", {7'h0, fdc_int}, 8'h00);
    check("rst_res", {7'h0, res_valid}, 8'h00);
    check("rst_busy", {7'h0, cmd_busy}, 8'h00);
    check("rst_fifo", {7'h0, fifo_disable_flag}, 8'h01);
    rst <= 1'b0;
    // configure was undone by reset; the next code must still be served
    issue('{8'h00});
    pop("post_rst", 8'h80);
    print_verdict();
  end
endmodule : floppy_command_set_part_bench
`default_nettype wire
